// [common/ldc_regs.svh]
// Purpose: Constants for the four-channel linear regulator control block
// Assumes: Included by bare name from package and design files
// Notes:   Voltage codes are 4 bits; output levels are in millivolts
`ifndef LDC_REGS_SVH
`define LDC_REGS_SVH

`define LDC_NUM_CH        4
`define LDC_HW_CH         1
`define LDC_CODE_W        4
`define LDC_MV_W          13
`define LDC_EN_RESET      1'b0
`define LDC_CODE_RESET    4'h0
`define LDC_MV_0          13'd1500
`define LDC_MV_1          13'd1600
`define LDC_MV_2          13'd1800
`define LDC_MV_3          13'd1850
`define LDC_MV_4          13'd2150
`define LDC_MV_5          13'd2500
`define LDC_MV_6          13'd2800
`define LDC_MV_7          13'd3000
`define LDC_MV_8          13'd3100
`define LDC_MV_9          13'd3150
`define LDC_MV_10         13'd3200
`define LDC_MV_11         13'd3300
`define LDC_MV_12         13'd3350
`define LDC_MV_13         13'd1650
`define LDC_MV_14         13'd1700
`define LDC_MV_15         13'd5000

`endif

// [common/ldc_pkg.sv]
// Purpose: Types shared by the regulator control block
// Assumes: ldc_regs.svh supplies the widths
// Notes:   Types only
`include "ldc_regs.svh"
package ldc_pkg;
    typedef logic [`LDC_CODE_W-1:0] ldc_code_t;
    typedef logic [`LDC_MV_W-1:0]   ldc_mv_t;

    typedef enum logic [1:0] {
        LDC_OFF_PULLDOWN = 2'b00,
        LDC_ON_REGULATE  = 2'b01,
        LDC_ON_SWITCH    = 2'b10,
        LDC_OFF_BENCH    = 2'b11
    } ldc_mode_e;

    typedef enum logic [1:0] {
        LDC_SEQ_IDLE = 2'b00,
        LDC_SEQ_LOAD = 2'b01,
        LDC_SEQ_RUN  = 2'b10
    } ldc_seq_e;

    typedef struct packed {
        logic      run_state_output_enable;
        logic      standby_state_output_enable;
        ldc_code_t run_voltage_code;
        ldc_code_t standby_voltage_code;
        logic      pass_through_current_limit_enable;
    } ldc_sw_cfg_s;

    typedef struct packed {
        logic      fused_pass_through_select;
        ldc_code_t fused_default_voltage_code;
        logic      in_power_up_sequence;
    } ldc_fuse_s;

    typedef struct packed {
        ldc_mode_e mode;
        logic      output_on;
        logic      pulldown_on;
        logic      bench_pulldown_on;
        logic      current_limit_on;
        ldc_code_t voltage_code;
        ldc_mv_t   voltage_mv;
    } ldc_ch_out_s;
endpackage

// [design/ldc_channel.sv]
// Purpose: One regulator channel: enable state, voltage codes and output mode
// Assumes: All inputs are on mclk_i
// Notes:   Software writes are level-held requests sampled each cycle
`timescale 1ns/10ps
`include "ldc_regs.svh"
module ldc_channel (
    input  wire logic                 mclk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 load_defaults_i,
    input  wire logic                 seq_enable_i,
    input  wire logic                 standby_i,
    input  wire logic                 idle_i,
    input  wire logic                 bench_mode_enable_i,
    input  wire logic                 sw_write_i,
    input  wire ldc_pkg::ldc_sw_cfg_s sw_cfg_i,
    input  wire ldc_pkg::ldc_fuse_s   fuse_i,
    input  wire logic                 hw_ctrl_i,
    input  wire logic                 hw_enable_i,
    input  wire ldc_pkg::ldc_code_t   hw_code_i,
    output ldc_pkg::ldc_sw_cfg_s      cfg_o,
    output ldc_pkg::ldc_ch_out_s      ch_o
);
    import ldc_pkg::*;

    logic      run_en_q;
    logic      stby_en_q;
    ldc_code_t run_code_q;
    ldc_code_t stby_code_q;
    logic      ilim_en_q;
    logic      act_en;
    ldc_code_t act_code;
    ldc_ch_out_s ch_d;
    ldc_ch_out_s ch_q;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_en_q  <= `LDC_EN_RESET;
            stby_en_q <= `LDC_EN_RESET;
        end else if (load_defaults_i) begin
            run_en_q  <= `LDC_EN_RESET;
            stby_en_q <= `LDC_EN_RESET;
        end else if (seq_enable_i && fuse_i.in_power_up_sequence) begin
            run_en_q  <= 1'b1;
            stby_en_q <= 1'b1;
        end else if (sw_write_i) begin
            run_en_q  <= sw_cfg_i.run_state_output_enable;
            stby_en_q <= sw_cfg_i.standby_state_output_enable;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_code_q  <= `LDC_CODE_RESET;
            stby_code_q <= `LDC_CODE_RESET;
        end else if (load_defaults_i) begin
            run_code_q  <= fuse_i.fused_default_voltage_code;
            stby_code_q <= fuse_i.fused_default_voltage_code;
        end else if (sw_write_i) begin
            run_code_q  <= sw_cfg_i.run_voltage_code;
            stby_code_q <= sw_cfg_i.standby_voltage_code;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ilim_en_q <= `LDC_EN_RESET;
        end else if (load_defaults_i) begin
            ilim_en_q <= `LDC_EN_RESET;
        end else if (sw_write_i) begin
            ilim_en_q <= sw_cfg_i.pass_through_current_limit_enable;
        end
    end

    always_comb begin
        if (hw_ctrl_i) begin
            act_en   = hw_enable_i;
            act_code = hw_code_i;
        end else if (standby_i) begin
            act_en   = stby_en_q;
            act_code = stby_code_q;
        end else begin
            act_en   = run_en_q;
            act_code = run_code_q;
        end
    end

    function automatic ldc_mv_t code_to_mv(input ldc_code_t code);
        case (code)
            4'h0:    code_to_mv = `LDC_MV_0;
            4'h1:    code_to_mv = `LDC_MV_1;
            4'h2:    code_to_mv = `LDC_MV_2;
            4'h3:    code_to_mv = `LDC_MV_3;
            4'h4:    code_to_mv = `LDC_MV_4;
            4'h5:    code_to_mv = `LDC_MV_5;
            4'h6:    code_to_mv = `LDC_MV_6;
            4'h7:    code_to_mv = `LDC_MV_7;
            4'h8:    code_to_mv = `LDC_MV_8;
            4'h9:    code_to_mv = `LDC_MV_9;
            4'ha:    code_to_mv = `LDC_MV_10;
            4'hb:    code_to_mv = `LDC_MV_11;
            4'hc:    code_to_mv = `LDC_MV_12;
            4'hd:    code_to_mv = `LDC_MV_13;
            4'he:    code_to_mv = `LDC_MV_14;
            default: code_to_mv = `LDC_MV_15;
        endcase
    endfunction

    always_comb begin
        ch_d              = '0;
        ch_d.voltage_code = act_code;
        ch_d.voltage_mv   = code_to_mv(act_code);
        if (idle_i) begin
            // Bench pull-down only when enabled; otherwise the normal discharge path
            ch_d.mode              = bench_mode_enable_i ? LDC_OFF_BENCH : LDC_OFF_PULLDOWN;
            ch_d.bench_pulldown_on = bench_mode_enable_i;
            ch_d.pulldown_on       = ~bench_mode_enable_i;
        end else if (!act_en) begin
            ch_d.mode        = LDC_OFF_PULLDOWN;
            ch_d.pulldown_on = 1'b1;
        end else if (fuse_i.fused_pass_through_select) begin
            ch_d.mode             = LDC_ON_SWITCH;
            ch_d.output_on        = 1'b1;
            ch_d.current_limit_on = ilim_en_q;
        end else begin
            ch_d.mode      = LDC_ON_REGULATE;
            ch_d.output_on = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ch_q <= '0;
        end else begin
            ch_q <= ch_d;
        end
    end

    assign ch_o = ch_q;

    always_comb begin
        cfg_o                                   = '0;
        cfg_o.run_state_output_enable           = run_en_q;
        cfg_o.standby_state_output_enable       = stby_en_q;
        cfg_o.run_voltage_code                  = run_code_q;
        cfg_o.standby_voltage_code              = stby_code_q;
        cfg_o.pass_through_current_limit_enable = ilim_en_q;
    end
endmodule

// [design/ldc_top.sv]
// Purpose: Control of four linear regulator channels with sequencing and pin control
// Assumes: Software and fuse inputs are on mclk_i; pins are asynchronous
// Notes on behaviour
// - In run state, a channel is off when its run enable is 0.
// - In standby state, a channel is off when its standby enable is 0.
// - Sequenced channels get both enables set; others default to 0.
// - Regulator or switch mode comes only from a fused per-channel bit.
// - Active enable 0 gives output off with pull-down, any mode.
// - Active enable 1: regulator when fuse bit 0, switch when 1.
// - Separate 4-bit run and standby voltage codes per channel.
// - Power up loads both codes from the fused default code.
// - Code decodes to the fixed sixteen-entry millivolt table.
// - Second channel under pin control uses enable pin and select pin.
// - In switch mode the enable bit turns the switch on or off.
// - Switch current limit applies only while its enable bit is 1.
// - Bench mode in unpowered idle holds outputs on weak pull-down.
// Notes: Pin select picks between the run and standby codes of channel two
`timescale 1ns/10ps
`include "ldc_regs.svh"
module ldc_top (
    input  wire logic                 mclk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 power_up_i,
    input  wire logic                 power_down_i,
    input  wire logic                 standby_i,
    input  wire logic                 bench_mode_enable_i,
    input  wire logic [3:0]           sw_write_i,
    input  wire ldc_pkg::ldc_sw_cfg_s sw_cfg_i [4],
    input  wire ldc_pkg::ldc_fuse_s   fuse_i [4],
    input  wire logic                 hw_ctrl_i,
    input  wire logic                 hw_channel_enable_pin_i,
    input  wire logic                 hw_voltage_select_pin_i,
    output ldc_pkg::ldc_sw_cfg_s      cfg_o [4],
    output ldc_pkg::ldc_ch_out_s      ch_o [4],
    output logic                      unpowered_idle_state_o
);
    import ldc_pkg::*;

    ldc_seq_e  seq_q;
    ldc_seq_e  seq_d;
    logic      en_pin_s1_q;
    logic      en_pin_s2_q;
    logic      sel_pin_s1_q;
    logic      sel_pin_s2_q;
    ldc_code_t hw_code;

    // Pins are asynchronous; two stages before use
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_pin_s1_q  <= 1'b0;
            en_pin_s2_q  <= 1'b0;
            sel_pin_s1_q <= 1'b0;
            sel_pin_s2_q <= 1'b0;
        end else begin
            en_pin_s1_q  <= hw_channel_enable_pin_i;
            en_pin_s2_q  <= en_pin_s1_q;
            sel_pin_s1_q <= hw_voltage_select_pin_i;
            sel_pin_s2_q <= sel_pin_s1_q;
        end
    end

    // Select pin chooses between the stored run and standby codes of channel two
    assign hw_code = sel_pin_s2_q ? cfg_o[`LDC_HW_CH].standby_voltage_code
                                  : cfg_o[`LDC_HW_CH].run_voltage_code;

    always_comb begin
        seq_d = seq_q;
        case (seq_q)
            LDC_SEQ_IDLE: begin
                if (power_up_i) begin
                    seq_d = LDC_SEQ_LOAD;
                end
            end
            LDC_SEQ_LOAD: begin
                seq_d = LDC_SEQ_RUN;
            end
            LDC_SEQ_RUN: begin
                if (power_down_i) begin
                    seq_d = LDC_SEQ_IDLE;
                end
            end
            default: begin
                seq_d = LDC_SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seq_q <= LDC_SEQ_IDLE;
        end else begin
            seq_q <= seq_d;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            unpowered_idle_state_o <= 1'b1;
        end else begin
            unpowered_idle_state_o <= (seq_d == LDC_SEQ_IDLE);
        end
    end

    genvar g;
    generate
        for (g = 0; g < `LDC_NUM_CH; g++) begin : g_ch
            ldc_channel u_ch (
                .mclk_i              (mclk_i),
                .rst_n_i             (rst_n_i),
                .load_defaults_i     (seq_q == LDC_SEQ_IDLE && power_up_i),
                .seq_enable_i        (seq_q == LDC_SEQ_LOAD),
                .standby_i           (standby_i),
                .idle_i              (seq_q == LDC_SEQ_IDLE),
                .bench_mode_enable_i (bench_mode_enable_i),
                .sw_write_i          (sw_write_i[g] && seq_q == LDC_SEQ_RUN),
                .sw_cfg_i            (sw_cfg_i[g]),
                .fuse_i              (fuse_i[g]),
                .hw_ctrl_i           (hw_ctrl_i && (g == `LDC_HW_CH)),
                .hw_enable_i         (en_pin_s2_q),
                .hw_code_i           (hw_code),
                .cfg_o               (cfg_o[g]),
                .ch_o                (ch_o[g])
            );
        end
    endgenerate
endmodule

// [tb/ldc_checker.sv]
// Purpose: Port assertions for the regulator control top
// Assumes: Fuses are static
// Notes:   Outputs trail their cause by a cycle, so causes are held two cycles
`timescale 1ns/10ps
module ldc_checker
    import ldc_pkg::*;
(
    input  wire logic                 mclk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 power_up_i,
    input  wire logic                 standby_i,
    input  wire logic                 bench_mode_enable_i,
    input  wire ldc_pkg::ldc_sw_cfg_s cfg_o [4],
    input  wire ldc_pkg::ldc_fuse_s   fuse_i [4],
    input  wire ldc_pkg::ldc_ch_out_s ch_o [4],
    input  wire logic                 unpowered_idle_state_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic idle;
    assign idle = unpowered_idle_state_o;

    a_run_en_off: assert property ((!standby_i && !cfg_o[0].run_state_output_enable)[*2]
        |-> !ch_o[0].output_on) else $error("run off ignored");
    a_stby_en_off: assert property ((standby_i && !cfg_o[2].standby_state_output_enable)[*2]
        |-> !ch_o[2].output_on) else $error("standby off ignored");
    a_seq_enables: assert property (power_up_i && idle |-> ##[1:3]
        cfg_o[3].run_state_output_enable == fuse_i[3].in_power_up_sequence
        && cfg_o[3].standby_state_output_enable == fuse_i[3].in_power_up_sequence)
        else $error("sequence enables");
    a_mode_from_fuse: assert property (ch_o[1].mode == LDC_ON_SWITCH
        |-> fuse_i[1].fused_pass_through_select) else $error("mode not fused");
    a_off_pulldown: assert property (!ch_o[3].output_on && !idle && $past(!idle)
        |-> ch_o[3].pulldown_on && ch_o[3].mode == LDC_OFF_PULLDOWN)
        else $error("off without pulldown");
    a_code_load: assert property (power_up_i && idle |-> ##[1:2]
        cfg_o[2].run_voltage_code == fuse_i[2].fused_default_voltage_code
        && cfg_o[2].standby_voltage_code == fuse_i[2].fused_default_voltage_code)
        else $error("codes not loaded");
    a_run_code: assert property (($stable(cfg_o[3]) && !standby_i && !idle)[*2]
        ##0 ch_o[3].output_on |-> ch_o[3].voltage_code == cfg_o[3].run_voltage_code)
        else $error("run code not used");
    a_mv_top: assert property (ch_o[0].output_on && ch_o[0].voltage_code == 4'hf
        |-> ch_o[0].voltage_mv == 13'd5000) else $error("top code decode");
    a_ilim_switch: assert property (ch_o[2].current_limit_on |-> ch_o[2].mode == LDC_ON_SWITCH
        && (cfg_o[2].pass_through_current_limit_enable
        || $past(cfg_o[2].pass_through_current_limit_enable)))
        else $error("limit outside switch");
    a_bench_idle: assert property ((bench_mode_enable_i && idle)[*2]
        |-> ch_o[1].bench_pulldown_on && !ch_o[1].output_on)
        else $error("bench pulldown missing");
endmodule

bind ldc_top ldc_checker chk_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .power_up_i(power_up_i),
    .standby_i(standby_i), .bench_mode_enable_i(bench_mode_enable_i), .cfg_o(cfg_o),
    .fuse_i(fuse_i), .ch_o(ch_o), .unpowered_idle_state_o(unpowered_idle_state_o));

// [tb/tb.sv]
// Purpose: Self-checking bench for the regulator control top
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Pin changes get five cycles to pass the synchroniser
`timescale 1ns/10ps
module tb;
    import ldc_pkg::*;
    logic        clk, rst_n, pu, pd, stby, bench, hw, pen, psel, idle, idl;
    logic [3:0]  wr;
    logic [31:0] seed;
    int          fails, n_compared;
    int          mv_t [16] = '{1500, 1600, 1800, 1850, 2150, 2500, 2800, 3000,
                               3100, 3150, 3200, 3300, 3350, 1650, 1700, 5000};
    ldc_sw_cfg_s cfg [4], m [4], cfg_q [4];
    ldc_fuse_s   fz [4];
    ldc_ch_out_s ch [4];

    ldc_top dut_u (.mclk_i(clk), .rst_n_i(rst_n), .power_up_i(pu), .power_down_i(pd),
        .standby_i(stby), .bench_mode_enable_i(bench), .sw_write_i(wr), .sw_cfg_i(cfg),
        .fuse_i(fz), .hw_ctrl_i(hw), .hw_channel_enable_pin_i(pen),
        .hw_voltage_select_pin_i(psel), .cfg_o(cfg_q), .ch_o(ch),
        .unpowered_idle_state_o(idle));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic ldc_ch_out_s exp_ch(int c);
        ldc_ch_out_s e;
        logic        hc, en, sw;
        ldc_code_t   k;
        hc = hw && c == 1;
        sw = fz[c].fused_pass_through_select;
        en = hc ? pen : (stby ? m[c].standby_state_output_enable : m[c].run_state_output_enable);
        k = (hc ? psel : stby) ? m[c].standby_voltage_code : m[c].run_voltage_code;
        e = '0;
        // The selected code is reported even while the output is off
        e.voltage_code = k;
        e.voltage_mv = 13'(mv_t[k]);
        if (idl) begin
            e.mode = bench ? LDC_OFF_BENCH : LDC_OFF_PULLDOWN;
            e.bench_pulldown_on = bench;
            e.pulldown_on = !bench;
            return e;
        end
        e.output_on = en;
        e.pulldown_on = !en;
        e.mode = !en ? LDC_OFF_PULLDOWN : (sw ? LDC_ON_SWITCH : LDC_ON_REGULATE);
        e.current_limit_on = en && sw && m[c].pass_through_current_limit_enable;
        return e;
    endfunction

    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic fail(string s);
        fails++;
        $display("ERROR %0t %s", $time, s);
    endtask

    task automatic chk_cfg(int c, ldc_sw_cfg_s e);
        n_compared++;
        if (cfg_q[c] !== e) fail($sformatf("cfg ch%0d", c));
    endtask

    task automatic chk_idle(logic e);
        n_compared++;
        if (idle !== e) fail("idle state");
    endtask

    task automatic chk_ch(int c);
        ldc_ch_out_s e, g;
        e = exp_ch(c);
        g = ch[c];
        n_compared++;
        if (g !== e) fail($sformatf("output ch%0d", c));
    endtask

    task automatic complete_run();
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    initial begin
        seed = 94;
        {rst_n, pu, pd, stby, bench, hw, pen, psel, wr, fails, n_compared} = '0;
        idl = 1;
        for (int c = 0; c < 4; c++) begin
            cfg[c] = '0;
            fz[c] = '{c[0], 4'(rnd()), c != 2};
        end
        repeat (2) @(posedge clk);
        #1 rst_n = 1;
        for (int c = 0; c < 4; c++) chk_cfg(c, '0);
        chk_idle(1'b1);
        pu = 1;
        tick(1);
        pu = 0;
        for (int k = 0; k < 10 && idle; k++) tick(1);
        if (idle !== 1'b0) begin
            fail("no power up");
            complete_run();
        end
        idl = 0;
        tick(3);
        chk_idle(1'b0);
        for (int c = 0; c < 4; c++) begin
            m[c] = '{fz[c].in_power_up_sequence, fz[c].in_power_up_sequence,
                     fz[c].fused_default_voltage_code, fz[c].fused_default_voltage_code, 1'b0};
            chk_cfg(c, m[c]);
            chk_ch(c);
        end
        for (int i = 0; i < 32; i++) begin
            for (int c = 0; c < 4; c++) begin
                m[c] = ldc_sw_cfg_s'(11'(rnd()));
                m[c].run_voltage_code = 4'(i);
                cfg[c] = m[c];
            end
            stby = 1'(rnd());
            wr = 4'hf;
            tick(1);
            wr = 4'h0;
            tick(2);
            for (int c = 0; c < 4; c++) begin
                chk_cfg(c, m[c]);
                chk_ch(c);
            end
        end
        hw = 1;
        for (int i = 0; i < 8; i++) begin
            {stby, psel, pen} = 3'(i);
            tick(5);
            for (int c = 0; c < 4; c++) chk_ch(c);
        end
        hw = 0;
        bench = 1;
        pd = 1;
        tick(1);
        pd = 0;
        idl = 1;
        tick(3);
        chk_idle(1'b1);
        for (int c = 0; c < 4; c++) chk_ch(c);
        bench = 0;
        tick(2);
        for (int c = 0; c < 4; c++) chk_ch(c);
        complete_run();
    end
endmodule
